// >>> shared/anso_defs.svh
`ifndef ANSO_DEFS_SVH
`define ANSO_DEFS_SVH
// register byte addresses
`define ANSO_CTRL_ADDR     4'h0
`define ANSO_STATUS_ADDR   4'h4
`define ANSO_EST_ADDR      4'h8
`define ANSO_CORNER_ADDR   4'hc
`define ANSO_ADDR_W        4
// control register field positions
`define ANSO_EN_A_BIT      0
`define ANSO_EN_B_BIT      1
`define ANSO_OVR_BIT       2
`define ANSO_TRIM_EN_BIT   3
`define ANSO_HOLD_BIT      4
`define ANSO_COEFF_A_LSB   8
`define ANSO_COEFF_B_LSB   12
`define ANSO_GAIN_LSB      16
`define ANSO_TC_LSB        20
// reset values: override off (shaping follows the pin), gain 0 dB, trim off, tc code 0
`define ANSO_CTRL_RESET    32'h0000_0000
// loop time constant: 2^(20+code) sample clocks, last defined code 1011
`define ANSO_TC_BASE_LOG2  6'd20
`define ANSO_TC_MAX_CODE   4'hb
// correction limit: 10 mV against a 1500 mV full scale of 2^DW codes
`define ANSO_TRIM_LIMIT_MV 10
`define ANSO_FULL_SCALE_MV 1500
// gain factors in q2.14, 0 dB .. 3.5 dB in 0.5 dB steps
`define ANSO_GAIN_ONE      16'h4000
`define ANSO_GAIN_FRAC     14
`define ANSO_RESP_OKAY     2'h0
`define ANSO_RESP_SLVERR   2'h2
`endif

// >>> shared/anso_pkg.sv
package anso_pkg;
  typedef struct packed {
    logic [3:0] tc_sel;
    logic [2:0] gain;
    logic [3:0] coeff_b;
    logic [3:0] coeff_a;
    logic       hold;
    logic       trim_en;
    logic       override;
    logic       en_b;
    logic       en_a;
  } anso_ctrl_t;

  typedef struct packed {
    logic [10:0] center_x2000;
    logic [9:0]  corner_b_x1000;
    logic [9:0]  corner_a_x1000;
  } anso_corner_t;
endpackage

// >>> hw/anso_ctrl.sv
// Summary of operation
// - synchronised shaping pin decides shaping on/off by default
// - override bit hands shaping enable to the two register enable bits
// - each 4-bit coefficient maps to a corner frequency per fixed table
// - notch center is the midpoint of the two corner frequencies
// - reset clears the override, leaving shaping to the synchronised pin
// - gain 0 to 3.5 dB in half-dB steps, full scale shrinks with it
// - reset selects 0 dB gain, gain path active
// - when enabled, loop estimates dc offset, correction limited to 10 mV
// - enabled correction subtracts the estimate from every output sample
// - time constant 2^(20+code) samples; codes 1100 to 1111 reserved
// - hold stops estimate updates but keeps applying the last estimate
// - reset leaves offset correction disabled
`include "anso_defs.svh"

module anso_fifo #(
  parameter int W     = 11,
  parameter int DEPTH = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [PW:0]   cnt_reg, cnt_next;
  logic          push, pop;

  assign in_ready  = (cnt_reg != DEPTH[PW:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage needs no reset; occupancy guards every read
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule

module anso_ctrl #(
  parameter int DW    = 11,
  parameter int DEPTH = 8
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [`ANSO_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`ANSO_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    shaping_enable_pin,
  input  wire logic [DW-1:0]           smp_in_data,
  input  wire logic                    smp_in_valid,
  output logic                         smp_in_ready,
  output logic [DW-1:0]                smp_out_data,
  output logic                         smp_out_valid,
  input  wire logic                    smp_out_ready,
  output logic                         shaping_active,
  output anso_pkg::anso_corner_t       shaping_corner
);
  import anso_pkg::*;

  localparam int AW = DW + 36;
  localparam int PW = DW + 17;
  localparam logic signed [DW-1:0] TRIM_LIM =
    DW'((`ANSO_TRIM_LIMIT_MV * (1 << DW)) / `ANSO_FULL_SCALE_MV);
  localparam logic signed [DW-1:0] OUT_MAX = {1'b0, {(DW-1){1'b1}}};
  localparam logic signed [DW-1:0] OUT_MIN = {1'b1, {(DW-1){1'b0}}};

  function automatic logic [9:0] corner_x1000(input logic [3:0] c);
    case (c)
      4'h0: corner_x1000 = 10'd250;
      4'h1: corner_x1000 = 10'd270;
      4'h2: corner_x1000 = 10'd290;
      4'h3: corner_x1000 = 10'd311;
      4'h4: corner_x1000 = 10'd333;
      4'h5: corner_x1000 = 10'd357;
      4'h6: corner_x1000 = 10'd385;
      4'h7: corner_x1000 = 10'd420;
      4'h8: corner_x1000 = 10'd0;
      4'h9: corner_x1000 = 10'd80;
      4'ha: corner_x1000 = 10'd115;
      4'hb: corner_x1000 = 10'd143;
      4'hc: corner_x1000 = 10'd167;
      4'hd: corner_x1000 = 10'd189;
      4'he: corner_x1000 = 10'd210;
      default: corner_x1000 = 10'd230;
    endcase
  endfunction

  function automatic logic [15:0] gain_q14(input logic [2:0] g);
    case (g)
      3'h0: gain_q14 = `ANSO_GAIN_ONE;
      3'h1: gain_q14 = 16'h43cb;
      3'h2: gain_q14 = 16'h47cf;
      3'h3: gain_q14 = 16'h4c10;
      3'h4: gain_q14 = 16'h5092;
      3'h5: gain_q14 = 16'h5558;
      3'h6: gain_q14 = 16'h5a67;
      default: gain_q14 = 16'h5fc2;
    endcase
  endfunction

  // register bus
  anso_ctrl_t ctrl_reg, ctrl_next;
  logic       aw_reg, aw_next, w_reg, w_next, b_reg, b_next, r_reg, r_next;
  logic [`ANSO_ADDR_W-1:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [3:0]  ws_reg, ws_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] ctrl_word, ctrl_wr;
  logic [1:0]  pin_sync_reg, pin_sync_next;
  logic signed [DW-1:0] est_reg, est_next;
  logic trim_active;

  assign s_axi_awready = !aw_reg && !b_reg;
  assign s_axi_wready  = !w_reg && !b_reg;
  assign s_axi_bvalid  = b_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !r_reg;
  assign s_axi_rvalid  = r_reg;
  assign s_axi_rdata   = rd_reg;
  assign s_axi_rresp   = rresp_reg;

  assign ctrl_word = {8'h00, ctrl_reg.tc_sel, 1'b0, ctrl_reg.gain, ctrl_reg.coeff_b, ctrl_reg.coeff_a,
                      3'h0, ctrl_reg.hold, ctrl_reg.trim_en, ctrl_reg.override, ctrl_reg.en_b, ctrl_reg.en_a};

  always_comb begin
    aw_next    = aw_reg;
    w_next     = w_reg;
    b_next     = b_reg;
    awa_next   = awa_reg;
    wd_next    = wd_reg;
    ws_next    = ws_reg;
    bresp_next = bresp_reg;
    ctrl_next  = ctrl_reg;
    ctrl_wr    = ctrl_word;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_next  = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_next  = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    if (aw_reg && w_reg) begin
      aw_next    = 1'b0;
      w_next     = 1'b0;
      b_next     = 1'b1;
      bresp_next = `ANSO_RESP_OKAY;
      if (awa_reg[`ANSO_ADDR_W-1:2] == `ANSO_CTRL_ADDR >> 2) begin
        for (int i = 0; i < 4; i++) begin
          if (ws_reg[i]) begin
            ctrl_wr[8*i +: 8] = wd_reg[8*i +: 8];
          end
        end
        ctrl_next.en_a     = ctrl_wr[`ANSO_EN_A_BIT];
        ctrl_next.en_b     = ctrl_wr[`ANSO_EN_B_BIT];
        ctrl_next.override = ctrl_wr[`ANSO_OVR_BIT];
        ctrl_next.trim_en  = ctrl_wr[`ANSO_TRIM_EN_BIT];
        ctrl_next.hold     = ctrl_wr[`ANSO_HOLD_BIT];
        ctrl_next.coeff_a  = ctrl_wr[`ANSO_COEFF_A_LSB +: 4];
        ctrl_next.coeff_b  = ctrl_wr[`ANSO_COEFF_B_LSB +: 4];
        ctrl_next.gain     = ctrl_wr[`ANSO_GAIN_LSB +: 3];
        ctrl_next.tc_sel   = ctrl_wr[`ANSO_TC_LSB +: 4];
      end else if (awa_reg[`ANSO_ADDR_W-1:2] > `ANSO_CORNER_ADDR >> 2) begin
        bresp_next = `ANSO_RESP_SLVERR;
      end
      // status, estimate and corner words are read-only; writes are dropped
    end
    if (b_reg && s_axi_bready) begin
      b_next = 1'b0;
    end
  end

  always_comb begin
    r_next     = r_reg;
    rd_next    = rd_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      r_next     = 1'b1;
      rresp_next = `ANSO_RESP_OKAY;
      case (s_axi_araddr[`ANSO_ADDR_W-1:2])
        `ANSO_CTRL_ADDR >> 2:   rd_next = ctrl_word;
        `ANSO_STATUS_ADDR >> 2: rd_next = {29'h0, trim_active, pin_sync_reg[1], shaping_active};
        `ANSO_EST_ADDR >> 2:    rd_next = 32'(est_reg);
        `ANSO_CORNER_ADDR >> 2: rd_next = {1'b0, shaping_corner};
        default: begin
          rd_next    = 32'h0;
          rresp_next = `ANSO_RESP_SLVERR;
        end
      endcase
    end else if (r_reg && s_axi_rready) begin
      r_next = 1'b0;
    end
  end

  // only the second stage feeds logic; the first may be metastable
  assign pin_sync_next = {pin_sync_reg[0], shaping_enable_pin};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= 20'(`ANSO_CTRL_RESET);
      aw_reg       <= 1'b0;
      w_reg        <= 1'b0;
      b_reg        <= 1'b0;
      r_reg        <= 1'b0;
      awa_reg      <= '0;
      wd_reg       <= 32'h0;
      ws_reg       <= 4'h0;
      rd_reg       <= 32'h0;
      bresp_reg    <= 2'h0;
      rresp_reg    <= 2'h0;
      pin_sync_reg <= 2'h0;
    end else begin
      ctrl_reg     <= ctrl_next;
      aw_reg       <= aw_next;
      w_reg        <= w_next;
      b_reg        <= b_next;
      r_reg        <= r_next;
      awa_reg      <= awa_next;
      wd_reg       <= wd_next;
      ws_reg       <= ws_next;
      rd_reg       <= rd_next;
      bresp_reg    <= bresp_next;
      rresp_reg    <= rresp_next;
      pin_sync_reg <= pin_sync_next;
    end
  end

  // shaping arbitration; the coefficients are taken live, so the host loads
  // them first to avoid a transient notch position
  assign shaping_active = ctrl_reg.override ? (ctrl_reg.en_a && ctrl_reg.en_b)
                                            : pin_sync_reg[1];
  assign shaping_corner.corner_a_x1000 = corner_x1000(ctrl_reg.coeff_a);
  assign shaping_corner.corner_b_x1000 = corner_x1000(ctrl_reg.coeff_b);
  // center in units of fs/2000: sum of corners in fs/1000 halves exactly
  assign shaping_corner.center_x2000 = 11'(shaping_corner.corner_a_x1000)
                                     + 11'(shaping_corner.corner_b_x1000);

  // sample path
  logic [DW-1:0] fifo_data;
  logic          fifo_valid, take;
  logic signed [PW-1:0] prod;
  logic signed [DW+1:0] gained, corr;
  logic signed [AW-1:0] acc_reg, acc_next, acc_sh;
  logic [5:0]           shift;
  logic [DW-1:0]        out_reg, out_next;
  logic                 ov_reg, ov_next;

  anso_fifo #(.W(DW), .DEPTH(DEPTH)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   (smp_in_data),
    .in_valid  (smp_in_valid),
    .in_ready  (smp_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (take)
  );

  assign take        = !ov_reg || smp_out_ready;
  assign trim_active = ctrl_reg.trim_en;
  assign prod   = PW'($signed(fifo_data) * $signed({1'b0, gain_q14(ctrl_reg.gain)}));
  assign gained = (DW+2)'(prod >>> `ANSO_GAIN_FRAC);
  // a wrong write to a reserved code still gives a bounded loop
  assign shift  = (ctrl_reg.tc_sel > `ANSO_TC_MAX_CODE) ? `ANSO_TC_BASE_LOG2 + 6'(`ANSO_TC_MAX_CODE)
                                                        : `ANSO_TC_BASE_LOG2 + 6'(ctrl_reg.tc_sel);
  assign acc_sh = acc_reg >>> shift;

  always_comb begin
    est_next = est_reg;
    acc_next = acc_reg;
    if (!ctrl_reg.trim_en) begin
      acc_next = '0;
      est_next = '0;
    end else begin
      if (acc_sh > AW'(TRIM_LIM)) begin
        est_next = TRIM_LIM;
      end else if (acc_sh < -AW'(TRIM_LIM)) begin
        est_next = -TRIM_LIM;
      end else begin
        est_next = DW'(acc_sh);
      end
      // first-order loop: accumulator over 2^shift samples tracks the mean
      if (fifo_valid && take && !ctrl_reg.hold) begin
        acc_next = acc_reg + AW'(gained) - AW'(est_reg);
      end
    end
  end

  always_comb begin
    corr     = ctrl_reg.trim_en ? gained - (DW+2)'(est_reg) : gained;
    out_next = out_reg;
    ov_next  = ov_reg;
    if (take) begin
      ov_next = fifo_valid;
      if (fifo_valid) begin
        if (corr > (DW+2)'(OUT_MAX)) begin
          out_next = OUT_MAX;
        end else if (corr < (DW+2)'(OUT_MIN)) begin
          out_next = OUT_MIN;
        end else begin
          out_next = DW'(corr);
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg <= '0;
      est_reg <= '0;
      out_reg <= '0;
      ov_reg  <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      est_reg <= est_next;
      out_reg <= out_next;
      ov_reg  <= ov_next;
    end
  end

  assign smp_out_data  = out_reg;
  assign smp_out_valid = ov_reg;
endmodule

// >>> bench/anso_ctrl_properties.sv
module anso_ctrl_properties #(
  parameter int DW    = 11,
  parameter int DEPTH = 8
) (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic                   s_axi_rvalid,
  input wire logic                   shaping_enable_pin,
  input wire logic                   smp_in_valid,
  input wire logic                   smp_in_ready,
  input wire logic [DW-1:0]          smp_out_data,
  input wire logic                   smp_out_valid,
  input wire logic                   smp_out_ready,
  input wire logic                   shaping_active,
  input wire anso_pkg::anso_corner_t shaping_corner
);
  import anso_pkg::*;
  logic [4:0] occ_reg;
  logic [4:0] occ_next;
  // samples in flight span the fifo and the output register
  always_comb begin
    occ_next = occ_reg + 5'(smp_in_valid && smp_in_ready) - 5'(smp_out_valid && smp_out_ready);
  end
  always_ff @(posedge aclk) begin
    occ_reg <= aresetn ? occ_next : 5'h0;
  end
  function automatic logic cok(logic [9:0] c);
    return c inside {10'h0, 10'h50, 10'h73, 10'h8f, 10'ha7, 10'hbd, 10'hd2, 10'he6,
                     10'hfa, 10'h10e, 10'h122, 10'h137, 10'h14d, 10'h165, 10'h181, 10'h1a4};
  endfunction
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_center_mid;
    shaping_corner.center_x2000 == 11'(shaping_corner.corner_a_x1000) + 11'(shaping_corner.corner_b_x1000);
  endproperty
  a_center_mid: assert property (p_center_mid) else $error("notch center not midway");
  property p_corner_table;
    cok(shaping_corner.corner_a_x1000) && cok(shaping_corner.corner_b_x1000);
  endproperty
  a_corner_table: assert property (p_corner_table) else $error("corner not a table value");
  property p_reset_idle;
    $rose(aresetn) |-> !shaping_active && shaping_corner == {11'h1f4, 10'hfa, 10'hfa};
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
  // the pin reaches the output through two flops, so its cause is two samples back
  property p_pin_cause;
    $changed(shaping_active) && $past(aresetn, 3) |->
      $past(shaping_enable_pin, 2) != $past(shaping_enable_pin, 3) || $rose(s_axi_bvalid);
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("shaping changed without cause");
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read data late");
  property p_out_hold;
    smp_out_valid && !smp_out_ready |=> smp_out_valid && $stable(smp_out_data);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("stalled sample dropped");
  property p_fifo_bound;
    occ_reg <= 5'(DEPTH + 1) && (smp_in_ready || occ_reg >= 5'(DEPTH));
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("buffer occupancy wrong");
endmodule

bind anso_ctrl anso_ctrl_properties #(.DW(DW), .DEPTH(DEPTH)) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .shaping_enable_pin(shaping_enable_pin), .smp_in_valid(smp_in_valid), .smp_in_ready(smp_in_ready),
  .smp_out_data(smp_out_data), .smp_out_valid(smp_out_valid), .smp_out_ready(smp_out_ready),
  .shaping_active(shaping_active), .shaping_corner(shaping_corner));

// >>> bench/test_adc_noise_shape_gain_offset_ctrl.sv
module test_adc_noise_shape_gain_offset_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import anso_pkg::*;
  typedef struct {
    logic [31:0] ctrl;
    logic        pin;
    logic [10:0] x;
    logic [31:0] corner;
    logic        act;
    int          y;
  } anso_row_t;
  logic         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic         shaping_enable_pin, smp_in_valid, smp_in_ready, smp_out_valid, smp_out_ready, shaping_active;
  logic [3:0]   s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0]  s_axi_wdata, s_axi_rdata, d;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [10:0]  smp_in_data, smp_out_data, y;
  anso_corner_t shaping_corner;
  anso_row_t    rows[16];
  int           bad_count, check_count, k, j, e;
  int           ctab[16] = '{'h fa, 'h10e, 'h122, 'h137, 'h14d, 'h165, 'h181, 'h1a4,
                             'h0, 'h50, 'h73, 'h8f, 'ha7, 'hbd, 'hd2, 'he6};

  anso_ctrl #(.DW(11), .DEPTH(8)) dut_u (.*);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      bad_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 200) begin
      bad_count++;
      tally_and_finish;
    end
  endtask

  task automatic rst;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    tmo(n);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    tmo(n);
    v = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  // one sample through an empty pipeline; output ready stays high
  task automatic xfer(input logic [10:0] x, output logic [10:0] o);
    int n;
    n = 0;
    @(posedge aclk);
    smp_in_data <= x;
    smp_in_valid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (smp_in_ready) smp_in_valid <= 1'b0;
      o = smp_out_data;
    end while (smp_out_valid !== 1'b1 && n < 200);
    tmo(n);
  endtask

  // full-scale stream to move the offset estimate, then let the pipeline empty
  task automatic pump(input int cnt);
    int c, n;
    c = 0;
    n = 0;
    @(posedge aclk);
    smp_in_data <= 11'h3ff;
    smp_in_valid <= 1'b1;
    while (c < cnt && n < 4 * cnt) begin
      @(posedge aclk);
      n++;
      if (smp_in_ready) c++;
    end
    smp_in_valid <= 1'b0;
    if (c < cnt) tmo(200);
    repeat (12) @(posedge aclk);
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, shaping_enable_pin, smp_in_valid, smp_in_data} = '0;
    s_axi_wstrb = 4'hf;
    smp_out_ready = 1'b1;
    aresetn = 1'b0;
    for (int i = 0; i < 16; i++) begin
      real r;
      rows[i].ctrl = {12'h0, 1'b0, i[2:0], 4'(15 - i), i[3:0], 5'h0, i[2:0]};
      rows[i].pin = i[3];
      rows[i].x = (i < 8) ? 11'(600 + 50 * i) : 11'(-300 - 50 * i);
      rows[i].corner = 32'({11'(ctab[i] + ctab[15 - i]), 10'(ctab[15 - i]), 10'(ctab[i])});
      rows[i].act = i[2] ? (i[0] & i[1]) : i[3];
      r = $signed(rows[i].x) * 10.0 ** ((i % 8) / 40.0);
      rows[i].y = (r > 1023.0) ? 1023 : (r < -1024.0) ? -1024 : int'(r);
    end
    rst;
    axr(4'h0, d);
    chk(d, 32'h0);
    chk(32'(s_axi_rresp), 32'h0);
    chk(32'(shaping_active), 32'h0);
    chk(32'(shaping_corner), 32'({11'h1f4, 10'hfa, 10'hfa}));
    axw(4'h4, 32'hffff_ffff);
    chk(32'(s_axi_bresp), 32'h0);
    axr(4'h4, d);
    chk(d, 32'h0);
    xfer(11'h064, y);
    chk(32'(y), 32'h64);
    $display("reset test done");
    foreach (rows[i]) begin
      shaping_enable_pin <= rows[i].pin;
      axw(4'h0, rows[i].ctrl & 32'hffff_fff8);
      axw(4'h0, rows[i].ctrl);
      repeat (3) @(posedge aclk);
      chk(32'(shaping_active), 32'(rows[i].act));
      chk(32'(shaping_corner), rows[i].corner);
      axr(4'hc, d);
      chk(d, rows[i].corner);
      axr(4'h4, d);
      chk(d, 32'({rows[i].pin, rows[i].act}));
      xfer(rows[i].x, y);
      e = $signed(y) - rows[i].y;
      chk(32'(e >= -1 && e <= 1), 32'h1);
    end
    $display("row tests done");
    axw(4'h0, 32'h0);
    smp_out_ready <= 1'b0;
    smp_in_data <= 11'h1;
    smp_in_valid <= 1'b1;
    k = 0;
    repeat (20) begin
      @(posedge aclk);
      if (smp_in_ready) begin
        k++;
        smp_in_data <= 11'(k + 1);
      end
    end
    smp_in_valid <= 1'b0;
    chk(32'(k >= 8 && k <= 9), 32'h1);
    smp_out_ready <= 1'b1;
    j = 0;
    repeat (30) begin
      @(posedge aclk);
      if (smp_out_valid) begin
        chk(32'(smp_out_data), 32'(j + 1));
        j++;
      end
    end
    chk(j, k);
    $display("buffer test done");
    axw(4'h0, 32'h8);
    pump(5000);
    axr(4'h8, d);
    chk(d, 32'h4);
    xfer(11'h3ff, y);
    chk(32'(y), 32'h3fb);
    axw(4'h0, 32'h18);
    pump(3000);
    axr(4'h8, d);
    chk(d, 32'h4);
    xfer(11'h3ff, y);
    chk(32'(y), 32'h3fb);
    axw(4'h0, 32'h8);
    pump(12000);
    axr(4'h8, d);
    chk(d, 32'hd);
    xfer(11'h3ff, y);
    chk(32'(y), 32'h3f2);
    axw(4'h0, 32'h0);
    axr(4'h8, d);
    chk(d, 32'h0);
    xfer(11'h1f4, y);
    chk(32'(y), 32'h1f4);
    $display("offset test done");
    shaping_enable_pin <= 1'b0;
    axw(4'h0, 32'h007f_ff1f);
    rst;
    axr(4'h0, d);
    chk(d, 32'h0);
    chk(32'(shaping_active), 32'h0);
    $display("second reset test done");
    tally_and_finish;
  end
endmodule
